// ### src/pfsp_host.sv
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
// flash host controller: command sequences, status polling, mode tracking
module pfsp_host #(
    parameter int SETTLE_CYC = pfsp_pkg::SETTLE_CYC // wait before full-word reads
) (
    input wire logic clk, // system clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic [3:0] regAddr, // register address
    input wire logic [31:0] regWdata, // register write data
    input wire logic regWr, // write strobe
    input wire logic regRd, // read strobe
    output logic [31:0] regRdata, // read data, one cycle after strobe
    output logic [19:0] flAddr, // flash address
    output logic flCe_n, // chip select
    output logic flOe_n, // output enable
    output logic flWe_n, // write strobe
    output logic [15:0] flDqOut, // dq driven by host
    output logic flDqOe_n, // low while host drives dq
    input wire logic [15:0] flDqIn // dq from flash
);
    // own register map (word index)
    localparam logic [3:0] REG_CMD = 4'h0; // op in [2:0], writing starts
    localparam logic [3:0] REG_ADDR = 4'h1; // target address
    localparam logic [3:0] REG_DATA = 4'h2; // program data
    localparam logic [3:0] REG_STAT = 4'h3; // status
    localparam logic [3:0] REG_RDAT = 4'h4; // last read data

    typedef enum logic [2:0] {PFSP_IDLE, PFSP_ISSUE, PFSP_WAIT, PFSP_POLL,
        PFSP_SETTLE} pfsp_st_t;
    pfsp_st_t state; // sequencer state
    pfsp_pkg::pfsp_op_t op; // operation in progress
    logic [19:0] tAddr; // target address
    logic [15:0] tData; // target data
    logic [2:0] step; // write cycle index in the sequence
    logic [15:0] rdWord; // last read word
    logic lastToggle; // toggle bit of previous poll
    logic havePoll; // previous poll valid
    logic busyFlash; // internal operation running
    logic inQuery; // flash in query mode
    logic inId; // flash in id mode
    logic [19:0] settleCnt; // settle counter
    logic bcStart; // start one bus cycle
    logic havePollWait; // a poll read is in flight
    logic bcDone; // bus cycle finished
    logic [15:0] bcRd; // bus cycle read data

    // sequence length per op: program 4, erase 6, id/query 3, exit 1
    function automatic logic [2:0] seqLen(pfsp_pkg::pfsp_op_t o);
        case (o)
            pfsp_pkg::PFSP_OP_PROG: seqLen = 3'd4;
            pfsp_pkg::PFSP_OP_SECT, pfsp_pkg::PFSP_OP_BLOCK,
            pfsp_pkg::PFSP_OP_CHIP: seqLen = 3'd6;
            pfsp_pkg::PFSP_OP_ID, pfsp_pkg::PFSP_OP_QUERY: seqLen = 3'd3;
            pfsp_pkg::PFSP_OP_EXIT: seqLen = 3'd1;
            default: seqLen = 3'd0;
        endcase
    endfunction

    wire isErase = (op == pfsp_pkg::PFSP_OP_SECT) || (op == pfsp_pkg::PFSP_OP_BLOCK)
        || (op == pfsp_pkg::PFSP_OP_CHIP);
    wire isRead = (op == pfsp_pkg::PFSP_OP_READ);
    wire lastStep = (step == seqLen(op) - 3'd1);
    // third-cycle code by op
    wire [15:0] thirdCode = (op == pfsp_pkg::PFSP_OP_PROG) ? pfsp_pkg::CODE_PROG :
        (op == pfsp_pkg::PFSP_OP_ID) ? pfsp_pkg::CODE_ID :
        (op == pfsp_pkg::PFSP_OP_QUERY) ? pfsp_pkg::CODE_QUERY :
        (op == pfsp_pkg::PFSP_OP_EXIT) ? pfsp_pkg::CODE_EXIT : pfsp_pkg::CODE_ERASE;
    // final erase code
    wire [15:0] eraseCode = (op == pfsp_pkg::PFSP_OP_SECT) ? pfsp_pkg::CODE_SECTOR :
        (op == pfsp_pkg::PFSP_OP_BLOCK) ? pfsp_pkg::CODE_BLOCK : pfsp_pkg::CODE_CHIP;
    // erase address: sector or block field kept, rest zero; chip at 5555H
    wire [19:0] sectAddr = {tAddr[19:pfsp_pkg::SECTOR_LSB], 11'h000};
    wire [19:0] blockAddr = {tAddr[19:pfsp_pkg::BLOCK_LSB], 15'h0000};
    wire [19:0] eraseAddr = (op == pfsp_pkg::PFSP_OP_SECT) ? sectAddr :
        (op == pfsp_pkg::PFSP_OP_BLOCK) ? blockAddr : pfsp_pkg::ADDR_UNLOCK1;
    // unlock pattern: AA@5555, 55@2AAA, code@5555, AA, 55, final
    wire [2:0] pos = (op == pfsp_pkg::PFSP_OP_EXIT) ? 3'd2 : step;
    wire [19:0] cycAddr = (pos == 3'd1 || pos == 3'd4) ? pfsp_pkg::ADDR_UNLOCK2 :
        (pos == 3'd5) ? eraseAddr :
        (pos == 3'd3 && op == pfsp_pkg::PFSP_OP_PROG) ? tAddr : pfsp_pkg::ADDR_UNLOCK1;
    wire [15:0] cycData = (pos == 3'd1 || pos == 3'd4) ? pfsp_pkg::CODE_55 :
        (pos == 3'd2) ? thirdCode :
        (pos == 3'd5) ? eraseCode :
        (pos == 3'd3 && op == pfsp_pkg::PFSP_OP_PROG) ? tData : pfsp_pkg::CODE_AA;
    // toggle seen stable and poll bit final: operation finished
    wire toggleStill = havePoll && (bcRd[pfsp_pkg::TOGGLE_BIT] == lastToggle);
    wire pollDone = isErase ? bcRd[pfsp_pkg::POLL_BIT] :
        (bcRd[pfsp_pkg::POLL_BIT] == tData[pfsp_pkg::POLL_BIT]);
    wire cmdGo = regWr && (regAddr == REG_CMD) && (state == PFSP_IDLE);
    // all commands refused while the flash is busy
    wire cmdOk = !busyFlash;
    wire [31:0] statWord = {26'h0000000, inId, inQuery, busyFlash, 1'b0,
        1'b0, state != PFSP_IDLE};
    wire [31:0] rdMux = (regAddr == REG_STAT) ? statWord :
        (regAddr == REG_RDAT) ? {16'h0000, rdWord} :
        (regAddr == REG_ADDR) ? {12'h000, tAddr} :
        (regAddr == REG_DATA) ? {16'h0000, tData} : 32'h00000000;

    assign bcStart = (state == PFSP_ISSUE) || (state == PFSP_POLL && !bcDone
        && settleCnt == 20'h00000 && !havePollWait);

    pfsp_bus_cycle u_cycle (
        .clk(clk),
        .rst_n(rst_n),
        .start(bcStart),
        .isWrite(state == PFSP_ISSUE),
        .addrIn((state == PFSP_ISSUE) ? cycAddr : tAddr),
        .dataIn(cycData),
        .done(bcDone),
        .rdData(bcRd),
        .flAddr(flAddr),
        .flCe_n(flCe_n),
        .flOe_n(flOe_n),
        .flWe_n(flWe_n),
        .flDqOut(flDqOut),
        .flDqOe_n(flDqOe_n),
        .flDqIn(flDqIn)
    );

    // register bus slave
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            regRdata <= 32'h00000000;
            tAddr <= 20'h00000;
            tData <= 16'h0000;
        end else begin
            regRdata <= regRd ? rdMux : 32'h00000000;
            if (regWr && regAddr == REG_ADDR && state == PFSP_IDLE) begin
                tAddr <= regWdata[19:0];
            end
            if (regWr && regAddr == REG_DATA && state == PFSP_IDLE) begin
                tData <= regWdata[15:0];
            end
        end
    end

    // command sequencer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= PFSP_IDLE;
            op <= pfsp_pkg::PFSP_OP_READ;
            step <= 3'd0;
            rdWord <= 16'h0000;
            lastToggle <= 1'b0;
            havePoll <= 1'b0;
            havePollWait <= 1'b0;
            busyFlash <= 1'b0;
            inQuery <= 1'b0;
            inId <= 1'b0;
            settleCnt <= 20'h00000;
        end else begin
            case (state)
                PFSP_IDLE: begin
                    if (cmdGo && cmdOk) begin
                        op <= pfsp_pkg::pfsp_op_t'(regWdata[2:0]);
                        step <= 3'd0;
                        state <= (regWdata[2:0] == 3'd0) ? PFSP_POLL : PFSP_ISSUE;
                        havePoll <= 1'b0;
                    end
                end
                PFSP_ISSUE: begin
                    state <= PFSP_WAIT; // one write cycle per step
                end
                PFSP_WAIT: begin
                    if (bcDone) begin
                        step <= step + 3'd1;
                        if (!lastStep) begin
                            state <= PFSP_ISSUE;
                        end else if (op == pfsp_pkg::PFSP_OP_PROG || isErase) begin
                            busyFlash <= 1'b1;
                            state <= PFSP_POLL;
                        end else begin
                            inQuery <= (op == pfsp_pkg::PFSP_OP_QUERY);
                            inId <= (op == pfsp_pkg::PFSP_OP_ID);
                            state <= PFSP_IDLE;
                        end
                    end
                end
                PFSP_POLL: begin
                    if (bcStart) begin
                        havePollWait <= 1'b1;
                    end
                    if (bcDone) begin
                        havePollWait <= 1'b0;
                        rdWord <= bcRd;
                        lastToggle <= bcRd[pfsp_pkg::TOGGLE_BIT];
                        havePoll <= 1'b1;
                        if (isRead) begin
                            state <= PFSP_IDLE;
                        end else if (toggleStill && pollDone) begin
                            busyFlash <= 1'b0;
                            settleCnt <= 20'(SETTLE_CYC);
                            state <= PFSP_SETTLE;
                        end
                    end
                end
                default: begin
                    // wait out the settle time before trusting the whole word
                    if (settleCnt != 20'h00000) begin
                        settleCnt <= settleCnt - 20'h00001;
                    end else begin
                        state <= PFSP_IDLE;
                    end
                end
            endcase
        end
    end

    AST_SETTLE_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        (state == PFSP_SETTLE && settleCnt != 20'h00000) |=> state == PFSP_SETTLE)
        else $error("left settle early");
    AST_BUSY_NO_CMD: assert property (@(posedge clk) disable iff (!rst_n)
        busyFlash |-> !(state == PFSP_ISSUE)) else $error("command while busy");
    AST_EXIT_CLEARS: assert property (@(posedge clk) disable iff (!rst_n)
        (state == PFSP_WAIT && bcDone && lastStep && op == pfsp_pkg::PFSP_OP_EXIT)
        |=> !inQuery && !inId) else $error("exit did not clear mode");
    AST_PROG_BUSY: assert property (@(posedge clk) disable iff (!rst_n)
        (state == PFSP_WAIT && bcDone && lastStep && op == pfsp_pkg::PFSP_OP_PROG)
        |=> busyFlash && state == PFSP_POLL) else $error("program not polled");
    COV_PROG: cover property (@(posedge clk) disable iff (!rst_n)
        $fell(busyFlash) && op == pfsp_pkg::PFSP_OP_PROG);
    COV_ERASE: cover property (@(posedge clk) disable iff (!rst_n) $fell(busyFlash) && isErase);
    COV_QUERY: cover property (@(posedge clk) disable iff (!rst_n) $rose(inQuery));
endmodule

// ### src/pfsp_pkg.sv
package pfsp_pkg;
    // command addresses and data codes
    localparam logic [19:0] ADDR_UNLOCK1 = 20'h05555;
    localparam logic [19:0] ADDR_UNLOCK2 = 20'h02AAA;
    localparam logic [19:0] ADDR_MAKER = 20'h00000;
    localparam logic [19:0] ADDR_PART = 20'h00001;
    localparam logic [15:0] CODE_AA = 16'h00AA;
    localparam logic [15:0] CODE_55 = 16'h0055;
    localparam logic [15:0] CODE_PROG = 16'h00A0;
    localparam logic [15:0] CODE_ERASE = 16'h0080;
    localparam logic [15:0] CODE_ID = 16'h0090;
    localparam logic [15:0] CODE_QUERY = 16'h0098;
    localparam logic [15:0] CODE_EXIT = 16'h00F0;
    localparam logic [15:0] CODE_SECTOR = 16'h0030;
    localparam logic [15:0] CODE_BLOCK = 16'h0050;
    localparam logic [15:0] CODE_CHIP = 16'h0010;
    // status bit positions
    localparam int POLL_BIT = 7;
    localparam int TOGGLE_BIT = 6;
    // sector and block field lowest address bits
    localparam int SECTOR_LSB = 11;
    localparam int BLOCK_LSB = 15;
    // timing at 200 MHz
    localparam int CLK_PS = 5000;
    localparam int SETTLE_US = 1;
    localparam int SETTLE_CYC = (SETTLE_US * 1000000 + CLK_PS - 1) / CLK_PS;
    localparam int STROBE_NS = 5;
    // strobe held low longer than 5 ns: at least two cycles of 5 ns
    localparam int STROBE_CYC = (STROBE_NS * 1000 + CLK_PS - 1) / CLK_PS + 1;
    localparam int SETUP_CYC = 2;
    // host operations
    typedef enum logic [2:0] {
        PFSP_OP_READ, PFSP_OP_PROG, PFSP_OP_SECT, PFSP_OP_BLOCK,
        PFSP_OP_CHIP, PFSP_OP_ID, PFSP_OP_QUERY, PFSP_OP_EXIT
    } pfsp_op_t;
endpackage

// ### src/pfsp_bus_cycle.sv
`timescale 1ns/1ps
// one asynchronous bus cycle: a read or a we-controlled write
module pfsp_bus_cycle (
    input wire logic clk, // system clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic start, // one-cycle request
    input wire logic isWrite, // 1 write, 0 read
    input wire logic [19:0] addrIn, // cycle address
    input wire logic [15:0] dataIn, // write data
    output logic done, // one-cycle completion pulse
    output logic [15:0] rdData, // captured read data
    output logic [19:0] flAddr, // flash address
    output logic flCe_n, // chip select
    output logic flOe_n, // output enable
    output logic flWe_n, // write strobe
    output logic [15:0] flDqOut, // data driven to flash
    output logic flDqOe_n, // low while host drives dq
    input wire logic [15:0] flDqIn // data from flash
);
    typedef enum logic [1:0] {PFSP_BC_IDLE, PFSP_BC_SETUP, PFSP_BC_STROBE,
        PFSP_BC_HOLD} pfsp_bc_t;
    pfsp_bc_t state; // cycle phase
    logic [3:0] cnt; // phase counter
    logic wr; // latched direction
    // phase sequencing; address stands before strobe falls and after it rises
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= PFSP_BC_IDLE;
            cnt <= 4'h0;
            wr <= 1'b0;
            flAddr <= 20'h00000;
            flDqOut <= 16'h0000;
            flCe_n <= 1'b1;
            flOe_n <= 1'b1;
            flWe_n <= 1'b1;
            flDqOe_n <= 1'b1;
            rdData <= 16'h0000;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state)
                PFSP_BC_IDLE: begin
                    if (start) begin
                        // ce low, oe high for writes; oe low only for reads
                        wr <= isWrite;
                        flAddr <= addrIn;
                        flDqOut <= {8'h00, 8'h00} | dataIn;
                        flCe_n <= 1'b0;
                        flOe_n <= isWrite;
                        flDqOe_n <= !isWrite;
                        cnt <= 4'h0;
                        state <= PFSP_BC_SETUP;
                    end
                end
                PFSP_BC_SETUP: begin
                    cnt <= cnt + 4'h1;
                    if (cnt == 4'(pfsp_pkg::SETUP_CYC - 1)) begin
                        flWe_n <= !wr;
                        cnt <= 4'h0;
                        state <= PFSP_BC_STROBE;
                    end
                end
                PFSP_BC_STROBE: begin
                    cnt <= cnt + 4'h1;
                    // strobe kept low long enough to pass the glitch filter
                    if (cnt == 4'(pfsp_pkg::STROBE_CYC - 1)) begin
                        flWe_n <= 1'b1;
                        if (!wr) begin
                            rdData <= flDqIn;
                        end
                        cnt <= 4'h0;
                        state <= PFSP_BC_HOLD;
                    end
                end
                default: begin
                    // release bus and deselect: floats dq, standby
                    flCe_n <= 1'b1;
                    flOe_n <= 1'b1;
                    flDqOe_n <= 1'b1;
                    done <= 1'b1;
                    state <= PFSP_BC_IDLE;
                end
            endcase
        end
    end
    // write strobe only falls with oe high and ce low
    AST_WRITE_GATED: assert property (@(posedge clk) disable iff (!rst_n)
        (!flWe_n |-> !flCe_n && flOe_n)) else $error("write strobe ungated");
    AST_STROBE_WIDTH: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(flWe_n) |-> !flWe_n [*2]) else $error("write strobe too short");
    AST_NO_FIGHT: assert property (@(posedge clk) disable iff (!rst_n)
        (!flOe_n |-> flDqOe_n)) else $error("host drives dq during read");
    AST_DONE_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
        done |-> flCe_n && flWe_n) else $error("cycle ended with ce low");
    COV_WRITE: cover property (@(posedge clk) disable iff (!rst_n) $fell(flWe_n));
    COV_READ: cover property (@(posedge clk) disable iff (!rst_n) $fell(flOe_n));
endmodule

// ### verif/pfsp_flash_model.sv
`timescale 1ns/1ps
// behavioural flash: unlock decoder, status bits, id and query modes
module pfsp_flash_model #(
    parameter logic [15:0] MAKER_ID = 16'h1A2B, // arbitrary value
    parameter logic [15:0] PART_ID = 16'h3C4D, // arbitrary value
    parameter int PROG_CYC = 40, // internal program time in clocks
    parameter int ERASE_CYC = 80, // internal erase time in clocks
    parameter int SETTLE = 4 // clocks of unsettled data bits after completion
) (
    input wire logic clk, // timebase for internal operations
    input wire logic [19:0] flAddr, // address pins
    input wire logic flCe_n, // chip select
    input wire logic flOe_n, // output enable
    input wire logic flWe_n, // write strobe
    input wire logic [15:0] dqIn, // level on the dq wire
    output logic [15:0] dqOut, // data the array puts on the wire
    output int violations // count of host faults seen
);
    logic [15:0] mem [logic [19:0]]; // programmed words, absent means erased
    int step = 0; // unlock sequence position, 10 means program data next
    int busy = 0; // clocks left of the internal operation
    int settle = 0; // clocks left with unsettled data bits
    logic isErase = 1'b0; // internal operation is an erase
    logic [15:0] progData = 16'h0000; // word being programmed
    logic tog = 1'b0; // toggle status bit
    logic idMode = 1'b0; // identification reads active
    logic qMode = 1'b0; // query reads active
    logic [15:0] lastDrv = 16'h0000; // last value driven
    logic [19:0] wAddr = 20'h00000; // address latched at strobe fall
    realtime fallT = 0.0; // time of strobe fall

    initial violations = 0;

    // erased locations read all ones
    function automatic logic [15:0] rd(input logic [19:0] a);
        return mem.exists(a) ? mem[a] : 16'hFFFF;
    endfunction

    // word seen on a read cycle
    function automatic logic [15:0] readWord(input logic [19:0] a);
        logic [15:0] w;
        w = ~progData;
        w[6] = tog;
        if (busy > 0) begin
            if (isErase) w[7] = 1'b0;
            return w;
        end
        if (settle > 0) return rd(a) ^ 16'hFF3F;
        if (idMode && a == 20'h00000) return MAKER_ID;
        if (idMode && a == 20'h00001) return PART_ID;
        if (qMode) return {4'hC, a[11:0]};
        return rd(a);
    endfunction

    // leave id and query modes, back to array reads
    task automatic exitModes();
        idMode = 1'b0;
        qMode = 1'b0;
        step = 0;
    endtask

    // one qualified write cycle into the unlock decoder
    task automatic doWrite(input logic [19:0] a, input logic [15:0] d);
        logic [7:0] lo;
        logic [14:0] la;
        lo = d[7:0];
        la = a[14:0];
        if (busy > 0) return;
        if (step != 10 && d[15:8] !== 8'h00) violations++;
        case (step)
            0: begin
                if (lo == 8'hF0) exitModes();
                else step = (lo == 8'hAA && la == 15'h5555) ? 1 : 0;
            end
            1, 4: step = (lo == 8'h55 && la == 15'h2AAA) ? step + 1 : 0;
            3: step = (lo == 8'hAA && la == 15'h5555) ? 4 : 0;
            2: begin
                step = 0;
                if (la == 15'h5555) begin
                    if (lo == 8'hA0) step = 10;
                    if (lo == 8'h80) step = 3;
                    if (lo == 8'h90) idMode = 1'b1;
                    if (lo == 8'h98) qMode = 1'b1;
                    if (lo == 8'hF0) exitModes();
                end
            end
            5: begin
                step = 0;
                isErase = 1'b1;
                if (lo == 8'h30 || lo == 8'h50 || (lo == 8'h10 && la == 15'h5555)) begin
                    busy = ERASE_CYC;
                    foreach (mem[k]) begin
                        if ((lo == 8'h30 && k[19:11] == a[19:11]) || lo == 8'h10 ||
                            (lo == 8'h50 && k[19:15] == a[19:15])) mem[k] = 16'hFFFF;
                    end
                end
            end
            default: begin
                mem[a] = rd(a) & d;
                progData = d;
                isErase = 1'b0;
                busy = PROG_CYC;
                step = 0;
            end
        endcase
    endtask

    // address latched at strobe fall, oe must stay high in writes
    always @(negedge flWe_n) begin
        if (!flCe_n && !flOe_n) violations++;
        wAddr = flAddr;
        fallT = $realtime;
    end

    // data latched at strobe rise, short pulses ignored
    always @(posedge flWe_n) begin
        if (!flCe_n && flOe_n && $realtime - fallT >= 5.0) doWrite(wAddr, dqIn);
    end

    // each read during an operation flips the toggle bit
    always @(negedge flOe_n) begin
        if (!flCe_n && busy > 0) tog = ~tog;
    end

    // drive only on a selected read, released bus shows no stale value
    always @(flCe_n or flOe_n or flWe_n or flAddr or busy or settle or tog or idMode or qMode) begin
        if (!flCe_n && !flOe_n && flWe_n) begin
            dqOut = readWord(flAddr);
            lastDrv = dqOut;
        end else dqOut = ~lastDrv;
    end

    // internal operation timer, then a short unsettled spell
    always @(posedge clk) begin
        if (busy > 0) begin
            busy--;
            if (busy == 0) settle = SETTLE;
        end else if (settle > 0) settle--;
    end
endmodule

// ### verif/parallel_flash_status_protection_test.sv
`timescale 1ns/1ps
// register-level tests of the flash host against the flash model
module parallel_flash_status_protection_test;
    localparam logic [15:0] MAKER = 16'h1A2B; // arbitrary value
    localparam logic [15:0] PART = 16'h3C4D; // arbitrary value
    logic clk = 1'b0; // 200 MHz clock
    logic rst_n = 1'b0; // reset, active low
    logic [3:0] regAddr = 4'h0; // register address
    logic [31:0] regWdata = 32'h0; // register write data
    logic regWr = 1'b0; // write strobe
    logic regRd = 1'b0; // read strobe
    logic [31:0] regRdata; // read data
    logic [19:0] flAddr; // flash address
    logic flCe_n; // chip select
    logic flOe_n; // output enable
    logic flWe_n; // write strobe
    logic [15:0] flDqOut; // host dq drive
    logic flDqOe_n; // host dq enable
    logic [15:0] dqModel; // model dq drive
    wire logic [15:0] flDqIn; // resolved dq wire
    int errors = 0; // mismatches
    int tests_run = 0; // comparisons
    int violations; // host faults seen by the model
    logic [31:0] rdv; // scratch read value
    logic [35:0] progTab [3] = '{36'h00801_1234, 36'h00802_00FF, 36'h08000_8001}; // addr, data

    always #2.5 clk = ~clk;

    // host wins the wire while it drives
    assign flDqIn = flDqOe_n ? dqModel : flDqOut;

    pfsp_host #(.SETTLE_CYC(4)) u_dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .flAddr(flAddr), .flCe_n(flCe_n), .flOe_n(flOe_n), .flWe_n(flWe_n),
        .flDqOut(flDqOut), .flDqOe_n(flDqOe_n), .flDqIn(flDqIn));

    pfsp_flash_model #(.MAKER_ID(MAKER), .PART_ID(PART)) u_flash (.clk(clk), .flAddr(flAddr),
        .flCe_n(flCe_n), .flOe_n(flOe_n), .flWe_n(flWe_n), .dqIn(flDqIn), .dqOut(dqModel),
        .violations(violations));

    // verdict and end of run
    task automatic finish_test();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // compare one register value
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one-cycle register write
    task automatic regWrite(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    // one-cycle register read, data taken in the following cycle
    task automatic regRead(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask

    // poll status until sequencer and flash are both idle
    task automatic waitIdle();
        logic [31:0] s;
        int n;
        s = 32'h1;
        n = 0;
        while ((s & 32'h9) !== 32'h0 && n < 3000) begin
            regRead(4'h3, s);
            n++;
        end
        if (n >= 3000) check(s, 32'h0);
    endtask

    // load address and data, issue an operation, wait for it
    task automatic doOp(input logic [2:0] op, input logic [19:0] a, input logic [15:0] d);
        regWrite(4'h1, {12'h000, a});
        regWrite(4'h2, {16'h0000, d});
        regWrite(4'h0, {29'h0, op});
        waitIdle();
    endtask

    // read one flash word through the controller
    task automatic rdWord(input logic [19:0] a, output logic [31:0] d);
        doOp(3'h0, a, 16'h0000);
        regRead(4'h4, d);
    endtask

    // stop a hung run
    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        finish_test();
    end

    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        regRead(4'h3, rdv); check(rdv, 32'h0);
        regRead(4'hF, rdv); check(rdv, 32'h0);
        doOp(3'h5, 20'h00000, 16'h0000);
        regRead(4'h3, rdv); check(rdv & 32'h30, 32'h20);
        rdWord(20'h00000, rdv); check(rdv, {16'h0000, MAKER});
        rdWord(20'h00001, rdv); check(rdv, {16'h0000, PART});
        doOp(3'h7, 20'h00000, 16'h0000);
        regRead(4'h3, rdv); check(rdv & 32'h30, 32'h0);
        rdWord(20'h00000, rdv); check(rdv, 32'hFFFF);
        doOp(3'h6, 20'h00000, 16'h0000);
        regRead(4'h3, rdv); check(rdv & 32'h30, 32'h10);
        rdWord(20'h00010, rdv); check(rdv, 32'hC010);
        rdWord(20'h00011, rdv); check(rdv, 32'hC011);
        doOp(3'h7, 20'h00000, 16'h0000);
        rdWord(20'h00010, rdv); check(rdv, 32'hFFFF);
        for (int i = 0; i < 3; i++) begin
            doOp(3'h1, progTab[i][35:16], progTab[i][15:0]);
            rdWord(progTab[i][35:16], rdv); check(rdv, {16'h0000, progTab[i][15:0]});
        end
        // a chip erase issued while a program runs is dropped
        regWrite(4'h1, 32'h00803);
        regWrite(4'h2, 32'h5A5A);
        regWrite(4'h0, 32'h1);
        regWrite(4'h0, 32'h4);
        waitIdle();
        rdWord(20'h00803, rdv); check(rdv, 32'h5A5A);
        rdWord(20'h00801, rdv); check(rdv, 32'h1234);
        doOp(3'h2, 20'h00FFF, 16'h0000);
        rdWord(20'h00801, rdv); check(rdv, 32'hFFFF);
        rdWord(20'h08000, rdv); check(rdv, 32'h8001);
        doOp(3'h3, 20'h0F000, 16'h0000);
        rdWord(20'h08000, rdv); check(rdv, 32'hFFFF);
        doOp(3'h1, 20'hFFFFF, 16'h0F0F);
        regRead(4'h1, rdv);
        check(rdv, 32'hFFFFF);
        regRead(4'h2, rdv);
        check(rdv, 32'h0F0F);
        rdWord(20'hFFFFF, rdv); check(rdv, 32'h0F0F);
        doOp(3'h4, 20'h00000, 16'h0000);
        rdWord(20'hFFFFF, rdv); check(rdv, 32'hFFFF);
        check(32'(violations), 32'h0);
        finish_test();
    end
endmodule
